// >>> design/pgcp_top.sv
// Module: packet line-command port, request in and report packet out
//
// Overview of operation
// - Seven lines in bits 6..0 of one byte; bit 7 unused.
// - Byte 0 interface code 0x08 routes the request to the line handler.
// - Byte 0 equal 0x18 writes the lines from the data byte.
// - Bytes 1 and 3 are ignored for line requests.
// - Each data bit drives its line directly; 0x40 raises only the top line.
// - Read 0x08 returns sampled line state as response byte 4.
// - Success answers byte 0 ORed with done 0x20; bytes 1..3 echoed.
// - Undefined byte 0 answers byte 0 ORed with request error 0x80.
// - Requests arrive as set-report bytes; answers leave as report bytes.
`timescale 1ns/1ps
module pgcp_top #(
  parameter int LINE_W = pgcp_pkg::LINE_W
) (
  input  wire logic              CLK_I,
  input  wire logic              RST_B_I,
  input  wire logic              REQ_VALID_I,
  input  wire logic [7:0]        REQ_BYTE_I,
  input  wire logic              REQ_LAST_I,
  input  wire logic [LINE_W-1:0] LINE_IN_I,
  input  wire logic              RSP_READY_I,
  input  wire logic              SER_DONE_I,
  input  wire logic              SER_ERR_I,
  output logic                   REQ_READY_O,
  output logic                   RSP_VALID_O,
  output logic [7:0]             RSP_BYTE_O,
  output logic                   RSP_LAST_O,
  output logic                   SER_START_O,
  output logic [LINE_W-1:0]      LINE_OUT_O
);
  // ******************************************************
  // Types and state
  // ******************************************************
  typedef enum logic [1:0] {
    PGCP_IDLE = 2'b00,
    PGCP_RECV = 2'b01,
    PGCP_WAIT = 2'b10,
    PGCP_SEND = 2'b11
  } pgcp_state_t;

  pgcp_state_t       state_r, state_nxt;
  logic [7:0]        pkt_r [pgcp_pkg::PKT_BYTES];
  logic [2:0]        cnt_r;
  logic [LINE_W-1:0] line_r;
  logic [LINE_W-1:0] sync1_r, sync2_r;
  logic [7:0]        st_r;
  logic              req_ready_r, rsp_valid_r, rsp_last_r, ser_start_r;
  logic              wait_first_r;
  logic [7:0]        rsp_byte_r;
  logic [2:0]        rsp_len_r;

  pgcp_dec_if dif ();
  pgcp_decode u_dec (.dif(dif));
  assign dif.cmd = pkt_r[pgcp_pkg::IDX_CMD];

  // ******************************************************
  // Decoding
  // ******************************************************
  localparam logic [2:0] LAST_IDX = 3'(pgcp_pkg::PKT_BYTES - 1);
  wire       take_w    = REQ_VALID_I && req_ready_r;
  wire       end_rx_w  = take_w && (REQ_LAST_I || cnt_r == LAST_IDX);
  wire       give_w    = rsp_valid_r && RSP_READY_I;
  wire       line_w    = dif.is_line_rd || dif.is_line_wr;
  // Bit 7 of data has no line; only low bits are applied
  wire [LINE_W-1:0] wr_val_w = pkt_r[pgcp_pkg::IDX_DATA][LINE_W-1:0];
  wire [7:0] rd_byte_w = {{(8-LINE_W){1'b0}}, sync2_r};
  wire [2:0] next_cnt_w = cnt_r + 3'd1;
  wire [2:0] rx_len_w   = end_rx_w ? next_cnt_w : cnt_r;

  function automatic logic [7:0] rsp_at(input logic [2:0] idx);
    logic [7:0] b;
    b = pkt_r[idx];
    if (idx == 3'(pgcp_pkg::IDX_CMD)) begin
      b = pkt_r[pgcp_pkg::IDX_CMD] | st_r;
    end
    return b;
  endfunction : rsp_at

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PGCP_IDLE: state_nxt = PGCP_RECV;
      PGCP_RECV: if (end_rx_w) state_nxt = PGCP_WAIT;
      PGCP_WAIT: if (line_w || !dif.is_serial || SER_DONE_I || SER_ERR_I) state_nxt = PGCP_SEND;
      PGCP_SEND: if (give_w && rsp_last_r) state_nxt = PGCP_RECV;
      default:   state_nxt = PGCP_IDLE;
    endcase
  end

  // ******************************************************
  // Registers
  // ******************************************************
  always_ff @(posedge CLK_I) begin
    sync1_r <= LINE_IN_I;
    sync2_r <= sync1_r;
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      state_r <= PGCP_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ******************************************************
  // Line drive
  // ******************************************************
  // Address and length bytes never gate this; the host keeps length at one
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      line_r <= LINE_W'(pgcp_pkg::LINES_RST);
    end else if (state_r == PGCP_WAIT && dif.is_line_wr) begin
      line_r <= wr_val_w;
    end
  end

  // ******************************************************
  // Serial engine start
  // ******************************************************
  // Pulse only once the stored command is decoded, so line requests never start it
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      wait_first_r <= 1'b0;
      ser_start_r  <= 1'b0;
    end else begin
      wait_first_r <= (state_r == PGCP_RECV) && end_rx_w;
      ser_start_r  <= wait_first_r && dif.is_serial && (state_r == PGCP_WAIT);
    end
  end

  // ******************************************************
  // Response presentation
  // ******************************************************
  // Byte follows the index one cycle late; host takes it after that lag
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      rsp_byte_r <= pgcp_pkg::BYTE_ZERO;
      rsp_last_r <= 1'b0;
    end else if (state_r == PGCP_SEND) begin
      rsp_byte_r <= rsp_at(cnt_r);
      rsp_last_r <= (next_cnt_w == rsp_len_r) && !(give_w && rsp_last_r);
    end
  end

  // ******************************************************
  // Request intake and sequencing
  // ******************************************************

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      cnt_r       <= '0;
      rsp_len_r   <= '0;
      st_r        <= pgcp_pkg::BYTE_ZERO;
      req_ready_r <= 1'b0;
      rsp_valid_r <= 1'b0;
      for (int i = 0; i < pgcp_pkg::PKT_BYTES; i++) pkt_r[i] <= pgcp_pkg::BYTE_ZERO;
    end else begin
      case (state_r)
        PGCP_IDLE: begin
          req_ready_r <= 1'b1;
          cnt_r       <= '0;
        end
        PGCP_RECV: begin
          // Request bytes taken from set-report stream
          if (take_w) begin
            pkt_r[cnt_r] <= REQ_BYTE_I;
            cnt_r        <= next_cnt_w;
          end
          if (end_rx_w) begin
            req_ready_r <= 1'b0;
            rsp_len_r   <= rx_len_w;
          end
        end
        PGCP_WAIT: begin
          if (dif.is_line_rd) begin
            pkt_r[pgcp_pkg::IDX_DATA] <= rd_byte_w;
            if (rsp_len_r <= 3'(pgcp_pkg::IDX_DATA)) rsp_len_r <= 3'(pgcp_pkg::PKT_BYTES);
          end
          st_r <= (dif.is_serial && SER_ERR_I) ? pgcp_pkg::ST_INTF_ERROR : dif.status;
          if (state_nxt == PGCP_SEND) begin
            rsp_valid_r <= 1'b1;
            cnt_r       <= '0;
          end
        end
        PGCP_SEND: begin
          if (give_w && rsp_last_r) begin
            rsp_valid_r <= 1'b0;
            req_ready_r <= 1'b1;
            cnt_r       <= '0;
          end else if (give_w) begin
            cnt_r <= next_cnt_w;
          end
        end
        default: req_ready_r <= 1'b0;
      endcase
    end
  end

  // ******************************************************
  // Outputs
  // ******************************************************
  // Every output is a flop, so the host never sees decode glitches
  assign REQ_READY_O = req_ready_r;
  assign RSP_VALID_O = rsp_valid_r;
  assign RSP_BYTE_O  = rsp_byte_r;
  assign RSP_LAST_O  = rsp_last_r;
  assign SER_START_O = ser_start_r;
  assign LINE_OUT_O  = line_r;
endmodule : pgcp_top

// >>> design/pgcp_pkg.sv
// Package: constants for the packet line-command port
package pgcp_pkg;
  localparam int          PKT_BYTES      = 5;
  localparam logic [7:0]  OP_WRITE       = 8'h10;
  localparam logic [7:0]  INTF_LINES     = 8'h08;
  localparam logic [7:0]  CMD_LINE_RD    = 8'h08;
  localparam logic [7:0]  CMD_LINE_WR    = 8'h18;
  localparam logic [7:0]  ST_REQ_DONE    = 8'h20;
  localparam logic [7:0]  ST_INTF_ERROR  = 8'h40;
  localparam logic [7:0]  ST_REQ_ERROR   = 8'h80;
  localparam logic [7:0]  INTF_I2C_STD   = 8'h01;
  localparam logic [7:0]  INTF_I2C_FAST  = 8'h02;
  localparam logic [7:0]  INTF_SPI_16    = 8'h04;
  localparam logic [7:0]  INTF_SPI_8     = 8'h00;
  localparam logic [6:0]  LINES_RST      = 7'h00;
  localparam logic [7:0]  BYTE_ZERO      = 8'h00;
  localparam int          IDX_CMD        = 0;
  localparam int          IDX_ADDR_HI    = 1;
  localparam int          IDX_LEN        = 2;
  localparam int          IDX_ADDR_LO    = 3;
  localparam int          IDX_DATA       = 4;
  localparam int          LINE_W         = 7;
endpackage : pgcp_pkg

// >>> design/pgcp_dec_if.sv
// Interface: command byte carried to the decoder and its verdict back
`timescale 1ns/1ps
interface pgcp_dec_if;
  logic [7:0] cmd;
  logic       is_line_rd;
  logic       is_line_wr;
  logic       is_serial;
  logic [7:0] status;
  modport ctl (output cmd, input is_line_rd, input is_line_wr, input is_serial, input status);
  modport dec (input cmd, output is_line_rd, output is_line_wr, output is_serial, output status);
endinterface : pgcp_dec_if

// >>> design/pgcp_decode.sv
// Module: decodes the interface/operation byte of a request
`timescale 1ns/1ps
module pgcp_decode (
  pgcp_dec_if.dec dif
);
  wire [7:0] intf_w  = dif.cmd & ~pgcp_pkg::OP_WRITE;
  wire       bad_hi_w = (dif.cmd & ~(pgcp_pkg::OP_WRITE | 8'h0f)) != pgcp_pkg::BYTE_ZERO;
  wire       serial_w = (intf_w == pgcp_pkg::INTF_I2C_STD) || (intf_w == pgcp_pkg::INTF_I2C_FAST)
                     || (intf_w == pgcp_pkg::INTF_SPI_16) || (intf_w == pgcp_pkg::INTF_SPI_8);
  // Line interface selected by code in byte 0
  assign dif.is_line_rd = (dif.cmd == pgcp_pkg::CMD_LINE_RD);
  assign dif.is_line_wr = (dif.cmd == pgcp_pkg::CMD_LINE_WR);
  assign dif.is_serial  = serial_w && !bad_hi_w;
  // Anything else is malformed
  assign dif.status = (dif.is_line_rd || dif.is_line_wr || dif.is_serial)
                      ? pgcp_pkg::ST_REQ_DONE : pgcp_pkg::ST_REQ_ERROR;
endmodule : pgcp_decode

// >>> tb/pgcp_host.sv
// Host model: sends request packets and takes report packets
`timescale 1ns/1ps
module pgcp_host (
  input  wire logic       clk_i,
  input  wire logic       rdy_i,
  input  wire logic       rvld_i,
  input  wire logic [7:0] rbyte_i,
  output logic            vld_o,
  output logic [7:0]      byte_o,
  output logic            last_o,
  output logic            racc_o
);
  initial begin
    {vld_o, byte_o, last_o, racc_o} = 11'h000;
  end
  // Set-report bytes held until taken, then five report bytes collected
  task automatic xfer(input logic [39:0] req, input int n, output logic [39:0] rsp,
                      output bit bad);
    int k;
    bad = 0;
    for (int i = 0; i < n; i++) begin
      @(negedge clk_i);
      {vld_o, last_o, byte_o} = {1'b1, i == n - 1, req[8*i+:8]};
      for (k = 0; k < 20 && !rdy_i; k++) @(negedge clk_i);
      bad |= (k == 20);
    end
    @(negedge clk_i);
    // Released byte lane shows the inverse, never the stale value
    {vld_o, last_o, byte_o} = {2'b00, ~byte_o};
    for (int i = 0; i < 5; i++) begin
      for (k = 0; k < 20 && !rvld_i; k++) @(negedge clk_i);
      bad |= (k == 20);
      // Byte settles one cycle after valid
      @(negedge clk_i);
      rsp[8*i+:8] = rbyte_i;
      racc_o = 1'b1;
      @(negedge clk_i);
      racc_o = 1'b0;
    end
  endtask : xfer
endmodule : pgcp_host

// >>> tb/pgcp_asserts.sv
// Checker: port-level properties of the line-command port
`timescale 1ns/1ps
module pgcp_asserts (
  input wire logic       CLK_I,
  input wire logic       RST_B_I,
  input wire logic       REQ_VALID_I,
  input wire logic [7:0] REQ_BYTE_I,
  input wire logic       REQ_LAST_I,
  input wire logic       REQ_READY_O,
  input wire logic       RSP_READY_I,
  input wire logic       RSP_VALID_O,
  input wire logic       RSP_LAST_O,
  input wire logic       SER_START_O,
  input wire logic [6:0] LINE_OUT_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);
  logic [2:0] cnt_r;
  logic [7:0] cmd_r;
  logic [7:0] dat_r;
  wire take = REQ_VALID_I && REQ_READY_O;
  always_ff @(posedge CLK_I) begin
    cnt_r <= !RST_B_I ? 3'h0 : (take ? (REQ_LAST_I ? 3'h0 : cnt_r + 3'h1) : cnt_r);
    cmd_r <= !RST_B_I ? 8'h00 : ((take && cnt_r == 3'h0) ? REQ_BYTE_I : cmd_r);
    dat_r <= (take && cnt_r == 3'h4) ? REQ_BYTE_I : dat_r;
  end
  a_rst_low: assert property ($rose(RST_B_I) |-> LINE_OUT_O == 7'h00 && !RSP_VALID_O)
    else $error("lines or response not cleared by reset");
  a_lines_hold: assert property ($changed(LINE_OUT_O) |-> !REQ_READY_O)
    else $error("lines moved while idle");
  a_wr_drives: assert property (take && cnt_r == 3'h4 && cmd_r == 8'h18
    |=> ##[0:3] LINE_OUT_O == dat_r[6:0]) else $error("write data not on lines");
  a_line_no_ser: assert property (cmd_r[3] |-> !SER_START_O)
    else $error("line request sent to serial engine");
  a_busy_refuse: assert property (take && REQ_LAST_I |=> !REQ_READY_O [*2])
    else $error("request taken while busy");
  a_rsp_hold: assert property (RSP_VALID_O && !RSP_READY_I |=> RSP_VALID_O)
    else $error("response dropped before handshake");
  a_last_ends: assert property (RSP_VALID_O && RSP_READY_I && RSP_LAST_O |=> !RSP_VALID_O)
    else $error("response went on after last byte");
  a_rsp_busy: assert property (RSP_VALID_O |-> !REQ_READY_O)
    else $error("ready during response");
  a_ready_rst: assert property ($rose(RST_B_I) |-> ##[1:3] REQ_READY_O)
    else $error("not ready after reset");
  c_write: cover property (take && cnt_r == 3'h4 && cmd_r == 8'h18);
  c_rsp: cover property (RSP_VALID_O && RSP_READY_I);
  c_rst: cover property ($rose(RST_B_I));
endmodule : pgcp_asserts
bind pgcp_top pgcp_asserts u_chk (.CLK_I(CLK_I), .RST_B_I(RST_B_I), .REQ_VALID_I(REQ_VALID_I),
  .REQ_BYTE_I(REQ_BYTE_I), .REQ_LAST_I(REQ_LAST_I), .REQ_READY_O(REQ_READY_O),
  .RSP_READY_I(RSP_READY_I), .RSP_VALID_O(RSP_VALID_O), .RSP_LAST_O(RSP_LAST_O),
  .SER_START_O(SER_START_O), .LINE_OUT_O(LINE_OUT_O));

// >>> tb/tb.sv
// Testbench: random and corner line requests against the port
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0, rst_b = 1'b0, rdy, rvld, vld, last, racc;
  logic [7:0] rbyte, qb, d;
  logic [6:0] lin = 7'h00, lout;
  logic [15:0] seed = 16'h3504;
  logic [39:0] rsp;
  int n_fail = 0, compares = 0;
  bit bad;
  initial begin
    forever #25 clk = ~clk;
  end
  pgcp_top dut (.CLK_I(clk), .RST_B_I(rst_b), .REQ_VALID_I(vld), .REQ_BYTE_I(qb),
    .REQ_LAST_I(last), .LINE_IN_I(lin), .RSP_READY_I(racc), .SER_DONE_I(1'b0),
    .SER_ERR_I(1'b0), .REQ_READY_O(rdy), .RSP_VALID_O(rvld), .RSP_BYTE_O(rbyte),
    .RSP_LAST_O(), .SER_START_O(), .LINE_OUT_O(lout));
  pgcp_host u_host (.clk_i(clk), .rdy_i(rdy), .rvld_i(rvld), .rbyte_i(rbyte),
    .vld_o(vld), .byte_o(qb), .last_o(last), .racc_o(racc));
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr
  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic give_verdict;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict
  task automatic run(input logic [39:0] req, input int n, input logic [39:0] exp);
    u_host.xfer(req, n, rsp, bad);
    n_fail += bad;
    if (bad) give_verdict();
    check(rsp, exp);
  endtask : run
  // ******************************
  // Main sequence
  // ******************************
  initial begin
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    check(40'(lout), 40'h0);
    for (int t = 0; t < 12; t++) begin
      seed = lfsr(seed);
      d = (t == 0) ? 8'h40 : seed[7:0];
      // Address bytes random, length fixed at one
      run({d, seed[15:8], 8'h01, ~seed[15:8], 8'h18}, 5,
          {d, seed[15:8], 8'h01, ~seed[15:8], 8'h38});
      check(40'(lout), 40'(d[6:0]));
      lin = seed[14:8];
      run({8'h00, seed[7:0], 8'h01, seed[15:8], 8'h08}, 4,
          {1'b0, lin, seed[7:0], 8'h01, seed[15:8], 8'h28});
      $display("test pass %0d done", t);
    end
    run({8'hAA, 8'h05, 8'h02, 8'hA0, 8'h13}, 5, {8'hAA, 8'h05, 8'h02, 8'hA0, 8'h93});
    check(40'(lout), 40'(d[6:0]));
    $display("test malformed done");
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    check(40'(lout), 40'h0);
    $display("test second reset done");
    give_verdict();
  end
endmodule : tb
